// File: ssra_pkg.sv
// Purpose: shared constants and types of the serial register access slave
// Assumes: 24-bit frames, command byte first, most significant bit first
// Notes: imported whole by every design file except the synchroniser
// ==========================================================
// constants
package ssra_pkg;
  // frame layout
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
  localparam logic [CNT_W-1:0] CNT_FRAME = 5'h18;
  localparam logic [CNT_W-1:0] CNT_HDR_LAST = 5'h07;
  localparam logic [CNT_W-1:0] CNT_FIRST = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] TX_TOP = 5'h16;
  localparam logic [FRAME_BITS-1:0] STUCK_WORD = 24'hffffff;
  // command byte fields
  localparam int OP_HI = 23;
  localparam int OP_LO = 22;
  localparam int ADDR_HI = 21;
  localparam int ADDR_LO = 16;
  // register addresses
  localparam logic [5:0] ADDR_DRIVE = 6'h00;
  localparam logic [5:0] ADDR_RECOVERY = 6'h02;
  localparam logic [5:0] ADDR_SENSE = 6'h03;
  localparam logic [5:0] ADDR_CONFIG = 6'h3f;
  localparam logic [5:0] ADDR_STATUS [3] = '{6'h10, 6'h11, 6'h12};
  // identity addresses
  localparam logic [5:0] ID_ADDR_HEADER = 6'h00;
  localparam logic [5:0] ID_ADDR_VERSION = 6'h01;
  localparam logic [5:0] ID_ADDR_CODE1 = 6'h02;
  localparam logic [5:0] ID_ADDR_CODE2 = 6'h03;
  localparam logic [5:0] ID_ADDR_FRAME = 6'h3e;
  localparam logic [7:0] FRAME_WIDTH_ID = 8'h02;
  // global status byte bit positions
  localparam int GSB_FAULT = 7;
  localparam int GSB_TXERR = 6;
  localparam int GSB_RESETBAR = 5;
  localparam int GSB_TSD = 4;
  localparam int GSB_TW = 3;
  localparam int GSB_SUPPLY = 2;
  localparam int GSB_UNDERLOAD = 1;
  localparam int GSB_NOTREADY = 0;
  // configuration mask bits
  localparam int CFG_MASK_TW = 0;
  localparam int CFG_MASK_UL = 1;
  // reset values
  localparam logic [DATA_BITS-1:0] REG_RESET = 16'h0000;
  localparam logic [HDR_BITS-1:0] GSB_RESET = 8'h81;
  // access opcodes
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ = 2'b01,
    OP_READ_CLEAR = 2'b10,
    OP_IDENTITY = 2'b11
  } ssra_op_type;
endpackage : ssra_pkg

// File: ssra_link_if.sv
// Purpose: carrier between link-clock logic and system-clock core
// Assumes: core words are quasi-static while a frame runs
// Notes: link side drives frame capture, core side drives answers
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// link carrier
interface ssra_link_if;
  import ssra_pkg::*;
  logic [FRAME_BITS-1:0] rxWord;
  logic [CNT_W-1:0] bitCount;
  logic txBit;
  logic shifted;
  logic [HDR_BITS-1:0] gsbSnap;
  logic [DATA_BITS-1:0] respEven;
  logic [DATA_BITS-1:0] respOdd;
  modport link (output rxWord, bitCount, txBit, shifted,
                input gsbSnap, respEven, respOdd);
  modport core (input rxWord, bitCount, txBit, shifted,
                output gsbSnap, respEven, respOdd);
endinterface : ssra_link_if
`default_nettype wire

// File: ssra_sync.sv
// Purpose: two-stage level synchroniser into the system clock
// Assumes: input is a slow level from another domain
// Notes: first stage is read by the second stage only
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// synchroniser
module ssra_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // level in and out
  input wire logic asyncIn,
  output logic syncOut
);
  logic stageOne;
  // two flops in series
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stageOne <= RESET_LEVEL;
      syncOut <= RESET_LEVEL;
    end else begin
      stageOne <= asyncIn;
      syncOut <= stageOne;
    end
  end
endmodule : ssra_sync
`default_nettype wire

// File: ssra_link.sv
// Purpose: serial shifter running on the master's shift clock
// Assumes: shift clock toggles only while chip select is low
// Notes: chip select high clears frame-start state without a clock
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// link logic
module ssra_link
  import ssra_pkg::*;
(
  // serial pins
  input wire logic spiClk,
  input wire logic chipSelectN,
  input wire logic spiDataIn,
  // core side
  ssra_link_if.link lnk
);
  logic firstEdge;
  logic [FRAME_BITS-1:0] frameWord;
  logic [CNT_W-1:0] fallCount;
  // marks the first rising edge of a frame
  always_ff @(posedge spiClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      firstEdge <= 1'b1;
    end else begin
      firstEdge <= 1'b0;
    end
  end
  // input capture and clock count, kept after the frame
  always_ff @(posedge spiClk) begin
    if (firstEdge) begin
      lnk.bitCount <= CNT_FIRST;
      lnk.rxWord <= {{(FRAME_BITS-1){1'b0}}, spiDataIn};
    end else begin
      lnk.bitCount <= (lnk.bitCount == CNT_MAX) ? CNT_MAX : lnk.bitCount + CNT_FIRST;
      lnk.rxWord <= {lnk.rxWord[FRAME_BITS-2:0], spiDataIn};
    end
  end
  // response word: status byte first, data at header end
  always_ff @(posedge spiClk) begin
    if (firstEdge) begin
      frameWord <= {lnk.gsbSnap, REG_RESET};
    end else if (lnk.bitCount == CNT_HDR_LAST) begin
      frameWord[DATA_BITS-1:0] <= spiDataIn ? lnk.respOdd : lnk.respEven;
    end
  end
  // falling edges step through the response
  always_ff @(negedge spiClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      fallCount <= CNT_ZERO;
      lnk.shifted <= 1'b0;
    end else begin
      fallCount <= (fallCount == CNT_MAX) ? CNT_MAX : fallCount + CNT_FIRST;
      lnk.shifted <= 1'b1;
    end
  end
  // output bit of the current falling edge
  always_ff @(negedge spiClk) begin
    if (fallCount <= TX_TOP) begin
      lnk.txBit <= frameWord[TX_TOP - fallCount];
    end else begin
      lnk.txBit <= 1'b0;
    end
  end
endmodule : ssra_link
`default_nettype wire

// File: ssra_top.sv
// Purpose: serial register access slave of a half-bridge driver
// Assumes: system clock 125 MHz, master shift clock a separate domain
// Notes: control registers change only after a frame closes and status is read from frozen snapshots, so link reads are stable
// Notes on behaviour
// - slave only; input bit captured on each rising shift clock edge
// - output released and no transfer while chip select is high
// - fault summary driven within three system clocks after chip select falls, once the synchronised select is low
// - first rising edge loads the status byte into the output shifter, data at the last header bit
// - each later falling edge presents the next response bit
// - frame is 8-bit header plus 16-bit data, 24 bits total
// - both directions shift most significant bit first
// - status byte goes out with the command, then two data bytes
// - write answers with the register content before the write
// - identity bytes are returned in the upper data byte
// - chip select rising ends the frame
// - wrong clock count discards the frame and sets transmission error
// - all-ones frame forces standby and switches drivers off
// - opcode in bits 23:22, address in bits 21:16
// - opcodes: write, read, read-and-clear, identity read
// - read-and-clear returns content then clears the status register
// - status byte order and reset pattern as laid out in the package
// - decode control, status and configuration addresses
// - unused address bits are reserved, no extra selects
// - identity read returns header, code, version and frame width id
// - fault summary ORs all failures, warning and underload maskable
// - clock count other than 0 or 24 flags error, frame ignored
// - reset-bar reads 0 after reset or stuck fault, outputs off
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// top
module ssra_top
  import ssra_pkg::*;
#(
  // identity bytes, values arbitrary
  parameter logic [7:0] ID_HEADER = 8'h5a,
  parameter logic [7:0] ID_VERSION = 8'h01,
  parameter logic [7:0] ID_CODE1 = 8'h11,
  parameter logic [7:0] ID_CODE2 = 8'h22
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial pins
  input wire logic spiClk,
  input wire logic chipSelectN,
  input wire logic spiDataIn,
  output logic spiDataOut,
  output logic spiDataOutEn,
  // device condition inputs
  input wire logic thermalShutdown,
  input wire logic thermalWarning,
  input wire logic [DATA_BITS-1:0] overcurrentEvent,
  input wire logic [DATA_BITS-1:0] underloadEvent,
  input wire logic [DATA_BITS-1:0] supplyEvent,
  // register contents towards the driver
  output logic [DATA_BITS-1:0] driveModeControl,
  output logic [DATA_BITS-1:0] recoveryPwmControl,
  output logic [DATA_BITS-1:0] senseSelectControl,
  output logic [DATA_BITS-1:0] maskMappingConfig,
  output logic outputsEnabled
);
  // ==========================================================
  // declarations
  ssra_link_if lnk ();
  logic csHigh;
  logic csPrev;
  logic frameEnd;
  logic frameOk;
  logic frameBad;
  logic shiftSeen;
  logic clocked;
  ssra_op_type frameOp;
  logic [5:0] frameAddr;
  logic [DATA_BITS-1:0] frameData;
  logic [DATA_BITS-1:0] statusReg [3];
  logic [DATA_BITS-1:0] statusSnap [3];
  logic [DATA_BITS-1:0] statusEvent [3];
  logic transmissionError;
  logic resetBarFlag;
  logic notReadyFlag;
  logic supplyOrOvercurrentFlag;
  logic underloadFlag;
  logic faultSummary;
  logic [HDR_BITS-1:0] statusByte;
  logic [HDR_BITS-1:0] gsbSnap;

  // ==========================================================
  // link domain
  ssra_link u_link (
    .spiClk(spiClk),
    .chipSelectN(chipSelectN),
    .spiDataIn(spiDataIn),
    .lnk(lnk.link)
  );

  // chip select into the system clock
  ssra_sync #(
    .RESET_LEVEL(1'b1)
  ) u_cs_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn(chipSelectN),
    .syncOut(csHigh)
  );

  // falling edges seen, to tell a poll from a clocked frame
  ssra_sync #(.RESET_LEVEL(1'b0)) u_shift_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn(lnk.shifted),
    .syncOut(shiftSeen)
  );

  // ==========================================================
  // frame boundaries
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      csPrev <= 1'b1;
    end else begin
      csPrev <= csHigh;
    end
  end

  // link count is stale after a poll
  always_ff @(posedge clk) begin
    if (sys_rst || frameEnd) begin
      clocked <= 1'b0;
    end else if (shiftSeen) begin
      clocked <= 1'b1;
    end
  end

  // frame end on chip select rising; link words are frozen by now
  assign frameEnd = csHigh & ~csPrev;
  assign frameOp = ssra_op_type'(lnk.rxWord[OP_HI:OP_LO]);
  assign frameAddr = lnk.rxWord[ADDR_HI:ADDR_LO];
  assign frameData = lnk.rxWord[DATA_BITS-1:0];
  // zero clocks is a poll, exactly 24 is a frame, anything else is bad
  assign frameOk = frameEnd & (lnk.bitCount == CNT_FRAME)
                   & clocked & (lnk.rxWord != STUCK_WORD);
  assign frameBad = frameEnd & (lnk.bitCount != CNT_FRAME)
                    & clocked;

  // ==========================================================
  // control and configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      driveModeControl <= REG_RESET;
      recoveryPwmControl <= REG_RESET;
      senseSelectControl <= REG_RESET;
      maskMappingConfig <= REG_RESET;
    end else if (frameEnd && lnk.bitCount == CNT_FRAME && lnk.rxWord == STUCK_WORD) begin
      // stuck input: standby clears register content
      driveModeControl <= REG_RESET;
      recoveryPwmControl <= REG_RESET;
      senseSelectControl <= REG_RESET;
      maskMappingConfig <= REG_RESET;
    end else if (frameOk && frameOp == OP_WRITE) begin
      case (frameAddr)
        ADDR_DRIVE: begin
          driveModeControl <= frameData;
        end
        ADDR_RECOVERY: begin
          recoveryPwmControl <= frameData;
        end
        ADDR_SENSE: begin
          senseSelectControl <= frameData;
        end
        ADDR_CONFIG: begin
          maskMappingConfig <= frameData;
        end
        default: begin
          driveModeControl <= driveModeControl;
        end
      endcase
    end
  end

  // ==========================================================
  // sticky status registers and their frame snapshots
  assign statusEvent[0] = overcurrentEvent;
  assign statusEvent[1] = underloadEvent;
  assign statusEvent[2] = supplyEvent;

  generate
    for (genvar i = 0; i < 3; i++) begin : g_status
      logic clearHit;
      assign clearHit = frameOk && frameOp == OP_READ_CLEAR
                        && frameAddr == ADDR_STATUS[i];
      // hardware set wins over a read-and-clear in the same cycle
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          statusReg[i] <= REG_RESET;
        end else begin
          statusReg[i] <= (clearHit ? REG_RESET : statusReg[i]) | statusEvent[i];
        end
      end
      // snapshot tracks while idle and freezes for the frame
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          statusSnap[i] <= REG_RESET;
        end else if (csHigh) begin
          statusSnap[i] <= statusReg[i];
        end
      end
    end
  endgenerate

  // ==========================================================
  // transmission error flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      transmissionError <= 1'b0;
    end else if (frameBad) begin
      transmissionError <= 1'b1;
    end else if (frameOk) begin
      transmissionError <= 1'b0;
    end
  end

  // reset-bar and not-ready flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resetBarFlag <= 1'b0;
      notReadyFlag <= 1'b1;
    end else if (frameEnd && lnk.bitCount == CNT_FRAME && lnk.rxWord == STUCK_WORD) begin
      resetBarFlag <= 1'b0;
      notReadyFlag <= 1'b1;
    end else if (frameOk) begin
      resetBarFlag <= 1'b1;
      notReadyFlag <= 1'b0;
    end
  end

  // drivers only run out of reset and without thermal shutdown
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outputsEnabled <= 1'b0;
    end else begin
      outputsEnabled <= resetBarFlag & ~thermalShutdown;
    end
  end

  // ==========================================================
  // global status byte
  assign supplyOrOvercurrentFlag = (|statusReg[0]) | (|statusReg[2]);
  assign underloadFlag = |statusReg[1];
  // fault summary: every failure, reset-bar inverted, two maskable
  assign faultSummary = transmissionError | ~resetBarFlag | thermalShutdown
                        | (thermalWarning & ~maskMappingConfig[CFG_MASK_TW])
                        | supplyOrOvercurrentFlag
                        | (underloadFlag & ~maskMappingConfig[CFG_MASK_UL])
                        | notReadyFlag;

  always_comb begin
    statusByte = '0;
    statusByte[GSB_FAULT] = faultSummary;
    statusByte[GSB_TXERR] = transmissionError;
    statusByte[GSB_RESETBAR] = resetBarFlag;
    statusByte[GSB_TSD] = thermalShutdown;
    statusByte[GSB_TW] = thermalWarning;
    statusByte[GSB_SUPPLY] = supplyOrOvercurrentFlag;
    statusByte[GSB_UNDERLOAD] = underloadFlag;
    statusByte[GSB_NOTREADY] = notReadyFlag;
  end

  // status byte frozen while chip select is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gsbSnap <= GSB_RESET;
    end else if (csHigh) begin
      gsbSnap <= statusByte;
    end
  end

  assign lnk.gsbSnap = gsbSnap;

  // ==========================================================
  // in-frame response lookup
  function automatic logic [DATA_BITS-1:0] respFor(
    input ssra_op_type op,
    input logic [5:0] addr
  );
    logic [DATA_BITS-1:0] word;
    word = REG_RESET;
    if (op == OP_IDENTITY) begin
      // identity bytes go in the upper data byte
      case (addr)
        ID_ADDR_HEADER: begin
          word = {ID_HEADER, 8'h00};
        end
        ID_ADDR_VERSION: begin
          word = {ID_VERSION, 8'h00};
        end
        ID_ADDR_CODE1: begin
          word = {ID_CODE1, 8'h00};
        end
        ID_ADDR_CODE2: begin
          word = {ID_CODE2, 8'h00};
        end
        ID_ADDR_FRAME: begin
          word = {FRAME_WIDTH_ID, 8'h00};
        end
        default: begin
          word = REG_RESET;
        end
      endcase
    end else begin
      // a write answers with the content before the write
      case (addr)
        ADDR_DRIVE: begin
          word = driveModeControl;
        end
        ADDR_RECOVERY: begin
          word = recoveryPwmControl;
        end
        ADDR_SENSE: begin
          word = senseSelectControl;
        end
        ADDR_CONFIG: begin
          word = maskMappingConfig;
        end
        ADDR_STATUS[0]: begin
          word = statusSnap[0];
        end
        ADDR_STATUS[1]: begin
          word = statusSnap[1];
        end
        ADDR_STATUS[2]: begin
          word = statusSnap[2];
        end
        default: begin
          word = REG_RESET;
        end
      endcase
    end
    return word;
  endfunction : respFor

  // both candidates ready before the last header bit arrives
  assign lnk.respEven = respFor(ssra_op_type'(lnk.rxWord[6:5]),
                                {lnk.rxWord[4:0], 1'b0});
  assign lnk.respOdd = respFor(ssra_op_type'(lnk.rxWord[6:5]),
                               {lnk.rxWord[4:0], 1'b1});

  // ==========================================================
  // serial output pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      spiDataOutEn <= 1'b0;
    end else begin
      spiDataOutEn <= ~csHigh;
    end
  end

  // fault summary until the first falling edge, then response bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      spiDataOut <= 1'b0;
    end else if (csHigh) begin
      spiDataOut <= 1'b0;
    end else if (lnk.shifted) begin
      spiDataOut <= lnk.txBit;
    end else begin
      spiDataOut <= faultSummary;
    end
  end

endmodule : ssra_top
`default_nettype wire

// File: ssra_chk.sv
// Purpose: pin-level checks of the serial register access slave
// Assumes: chip select stays at least 4 clk in each level
// Notes: bound to ssra_top
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// checker
module ssra_chk
  import ssra_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial pins
  input wire logic spiClk,
  input wire logic chipSelectN,
  input wire logic spiDataOut,
  input wire logic spiDataOutEn,
  // register contents
  input wire logic [DATA_BITS-1:0] driveModeControl,
  input wire logic [DATA_BITS-1:0] recoveryPwmControl,
  input wire logic [DATA_BITS-1:0] senseSelectControl,
  input wire logic [DATA_BITS-1:0] maskMappingConfig,
  input wire logic outputsEnabled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // pin behaviour around chip select
  property p_rel_zero; !spiDataOutEn |-> !spiDataOut; endproperty
  property p_en_rise; $fell(chipSelectN) |-> ##[1:4] spiDataOutEn; endproperty
  property p_en_fall; $rose(chipSelectN) |-> ##[1:4] !spiDataOutEn; endproperty
  property p_cs_high_off; chipSelectN [*5] |-> !spiDataOutEn; endproperty
  property p_cs_low_on; !chipSelectN [*5] |-> spiDataOutEn; endproperty
  // output bit moves only while the shift clock is low
  property p_shift_fall;
    spiDataOutEn && $past(spiDataOutEn, 2) && $changed(spiDataOut) |-> !spiClk;
  endproperty
  // registers hold while a frame runs
  property p_regs_stable;
    !chipSelectN && !$past(chipSelectN) |->
      $stable({driveModeControl, recoveryPwmControl, senseSelectControl, maskMappingConfig});
  endproperty
  property p_reset_state;
    $fell(sys_rst) |-> !outputsEnabled && !spiDataOutEn && driveModeControl == 16'h0000;
  endproperty
  a_rel_zero: assert property (p_rel_zero) else $error("output not low while released");
  a_en_rise: assert property (p_en_rise) else $error("output not enabled after select");
  a_en_fall: assert property (p_en_fall) else $error("output not released at frame end");
  a_cs_high_off: assert property (p_cs_high_off) else $error("output driven while idle");
  a_cs_low_on: assert property (p_cs_low_on) else $error("output off while selected");
  a_shift_fall: assert property (p_shift_fall) else $error("output moved with clock high");
  a_regs_stable: assert property (p_regs_stable) else $error("register moved in frame");
  a_reset_state: assert property (p_reset_state) else $error("wrong state after reset");
  // main scenarios
  c_frame: cover property ($fell(chipSelectN));
  c_enable: cover property ($rose(spiDataOutEn));
  c_outputs: cover property ($fell(outputsEnabled));
endmodule : ssra_chk
bind ssra_top ssra_chk chk_u (.clk, .sys_rst, .spiClk, .chipSelectN, .spiDataOut,
  .spiDataOutEn, .driveModeControl, .recoveryPwmControl, .senseSelectControl,
  .maskMappingConfig, .outputsEnabled);
`default_nettype wire

// File: ssra_master.sv
// Purpose: serial master model driving the slave pins
// Assumes: 32 ns shift clock, made only inside frames
// Notes: frames are run by calling xfer
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// master model
module ssra_master (
  // serial pins
  output logic spiClk,
  output logic chipSelectN,
  output logic spiDataIn,
  input wire logic spiDataOut
);
  // idle levels
  initial begin
    spiClk = 1'b0;
    spiDataIn = 1'b0;
    #1 chipSelectN = 1'b1; // edge clears link frame state
  end
  // one frame of n clocks, own select line
  task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx,
                      output logic fault_summary);
    rx = 24'h000000;
    #3 chipSelectN = 1'b0;
    #40 fault_summary = spiDataOut;
    for (int i = 0; i < n; i++) begin
      spiDataIn = (i < 24) ? tx[23 - i] : 1'b0;
      #16 spiClk = 1'b1;
      if (i < 24) rx[23 - i] = spiDataOut;
      #16 spiClk = 1'b0;
    end
    #16 chipSelectN = 1'b1;
    spiDataIn = ~spiDataIn; // released line shows no stale bit
    #40;
  endtask : xfer
endmodule : ssra_master
`default_nettype wire

// File: ssra_bench.sv
// Purpose: self-checking bench of the serial register access slave
// Assumes: link clock made by the master model inside frames
// Notes: expectations come from a register model kept here
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bench
module ssra_bench
  import ssra_pkg::*;
;
  // identity values, arbitrary
  localparam logic [7:0] ID_H = 8'h3c;
  localparam logic [7:0] ID_V = 8'h07;
  localparam logic [7:0] ID_C1 = 8'h4b;
  localparam logic [7:0] ID_C2 = 8'h69;
  localparam logic [5:0] REG_A [8] = '{6'h00, 6'h02, 6'h03, 6'h3f, 6'h10, 6'h11, 6'h12, 6'h20};
  localparam logic [5:0] ID_A [5] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h3e};
  localparam int BAD_N [3] = '{8, 23, 25};
  logic clk, sys_rst, spiClk, chipSelectN, spiDataIn, spiDataOut, spiDataOutEn, outEn;
  logic [DATA_BITS-1:0] ocEv, ulEv, svEv, drv, rec, sen, cfg;
  logic txErr, resBar, thermal_shutdown, tw;
  logic [15:0] ctl [4];
  logic [15:0] st [3];
  logic [15:0] seed;
  int numErrors, checkCount, cycles;
  wire misoLine;
  assign misoLine = spiDataOutEn ? spiDataOut : 1'bz;
  // design and master
  ssra_top #(.ID_HEADER(ID_H), .ID_VERSION(ID_V), .ID_CODE1(ID_C1), .ID_CODE2(ID_C2)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .spiClk(spiClk), .chipSelectN(chipSelectN),
    .spiDataIn(spiDataIn), .spiDataOut(spiDataOut), .spiDataOutEn(spiDataOutEn),
    .thermalShutdown(thermal_shutdown), .thermalWarning(tw), .overcurrentEvent(ocEv),
    .underloadEvent(ulEv), .supplyEvent(svEv), .driveModeControl(drv),
    .recoveryPwmControl(rec), .senseSelectControl(sen), .maskMappingConfig(cfg),
    .outputsEnabled(outEn));
  ssra_master mst_u (.spiClk(spiClk), .chipSelectN(chipSelectN), .spiDataIn(spiDataIn),
    .spiDataOut(misoLine));
  // clock and hang limit
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      numErrors++;
      endSim();
    end
  end
  task automatic endSim();
    if (numErrors == 0 && checkCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : endSim
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  function automatic void nextRand();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
  endfunction : nextRand
  // model lookups
  function automatic int regIdx(input logic [5:0] a);
    for (int i = 0; i < 7; i++) if (REG_A[i] == a) return i;
    return 7;
  endfunction : regIdx
  function automatic logic [15:0] answer(input logic [1:0] op, input logic [5:0] a);
    logic [7:0] id [5];
    int k;
    id = '{ID_H, ID_V, ID_C1, ID_C2, FRAME_WIDTH_ID};
    k = regIdx(a);
    if (op == OP_IDENTITY) begin
      for (int i = 0; i < 5; i++) if (ID_A[i] == a) return {id[i], 8'h00};
      return 16'h0000;
    end
    if (k < 4) return ctl[k];
    if (k < 7) return st[k-4];
    return 16'h0000;
  endfunction : answer
  function automatic logic [7:0] gsb();
    logic [7:0] g;
    g = {1'b0, txErr, resBar, thermal_shutdown, tw, (|st[0]) | (|st[2]), |st[1], ~resBar};
    g[7] = g[6] | g[4] | (g[3] & ~ctl[3][CFG_MASK_TW]) | g[2];
    g[7] = g[7] | (g[1] & ~ctl[3][CFG_MASK_UL]) | g[0];
    return g;
  endfunction : gsb
  // status events while idle
  task automatic events();
    @(negedge clk);
    nextRand();
    ocEv = seed & 16'h0101;
    ulEv = seed & 16'h0a00;
    svEv = seed & 16'h0030;
    {thermal_shutdown, tw} = seed[15:14];
    st[0] = st[0] | ocEv;
    st[1] = st[1] | ulEv;
    st[2] = st[2] | svEv;
    @(negedge clk);
    {ocEv, ulEv, svEv} = 48'h000000000000;
    repeat (3) @(negedge clk);
  endtask : events
  // one frame with model update and checks
  task automatic frame(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
                       input int n);
    logic [23:0] rx;
    logic fault_summary;
    logic [7:0] g;
    logic [15:0] ans;
    int k;
    g = gsb();
    ans = answer(op, a);
    k = regIdx(a);
    mst_u.xfer({op, a, d}, n, rx, fault_summary);
    repeat (4) @(negedge clk);
    check("poll", fault_summary, g[7]);
    if (n >= 8) check("status", rx[23:16], g);
    if (n == 24) check("answer", rx[15:0], ans);
    if (n != 24 && n != 0) txErr = 1'b1;
    else if (n == 24 && {op, a, d} == STUCK_WORD) begin
      resBar = 1'b0;
      for (int i = 0; i < 4; i++) ctl[i] = 16'h0000;
    end else if (n == 24) begin
      txErr = 1'b0;
      resBar = 1'b1;
      if (op == OP_WRITE && k < 4) ctl[k] = d;
      if (op == OP_READ_CLEAR && k > 3 && k < 7) st[k-4] = 16'h0000;
    end
    check("drive", drv, ctl[0]);
    check("recovery", rec, ctl[1]);
    check("sense", sen, ctl[2]);
    check("config", cfg, ctl[3]);
    check("enable", outEn, resBar & ~thermal_shutdown);
  endtask : frame
  // main sequence
  initial begin
    logic [1:0] op;
    logic [5:0] a;
    {ocEv, ulEv, svEv} = 48'h000000000000;
    sys_rst = 1'b1;
    seed = 16'h0056;
    txErr = 1'b0;
    resBar = 1'b0;
    {thermal_shutdown, tw} = 2'b00;
    ctl = '{REG_RESET, REG_RESET, REG_RESET, REG_RESET};
    st = '{REG_RESET, REG_RESET, REG_RESET};
    repeat (2) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    frame(OP_READ, ADDR_DRIVE, 16'h0000, 24);
    for (int i = 0; i < 8; i++) begin
      nextRand();
      frame(OP_WRITE, REG_A[i % 4], seed, 24);
    end
    for (int i = 0; i < 5; i++) frame(OP_IDENTITY, ID_A[i], 16'h0000, 24);
    for (int i = 0; i < 3; i++) begin
      events();
      frame(OP_READ, ADDR_STATUS[i], 16'h0000, 24);
      frame(OP_READ_CLEAR, ADDR_STATUS[i], 16'h0000, 24);
      frame(OP_READ, ADDR_STATUS[i], 16'h0000, 24);
    end
    foreach (BAD_N[j]) begin
      frame(OP_WRITE, ADDR_DRIVE, ~ctl[0], BAD_N[j]);
      frame(OP_READ, ADDR_DRIVE, 16'h0000, 0);
      frame(OP_READ, ADDR_DRIVE, 16'h0000, 24);
    end
    frame(OP_WRITE, 6'h20, 16'ha5c3, 24);
    frame(OP_READ, 6'h01, 16'h0000, 24);
    frame(OP_WRITE, ADDR_CONFIG, 16'h0000, 24);
    frame(OP_IDENTITY, 6'h3f, 16'hffff, 24);
    frame(OP_READ, ADDR_DRIVE, 16'h0000, 24);
    for (int i = 0; i < 40; i++) begin
      events();
      nextRand();
      op = seed[1:0];
      a = (op == OP_IDENTITY) ? ID_A[seed[4:2] % 5] : REG_A[seed[4:2]];
      if (regIdx(a) < 4 && op == OP_READ_CLEAR) op = OP_READ;
      if (regIdx(a) > 3 && regIdx(a) < 7 && op == OP_WRITE) op = OP_READ;
      nextRand();
      frame(op, a, seed, 24);
    end
    endSim();
  end
endmodule : ssra_bench
`default_nettype wire
